//--- angle_turns_readout_unlock.sv
// Angle and turns result registers with the configuration unlock key
// Behaviour
// - Rotation count word carries fixed tag 110 in bits 15:13.
// - Rotation count bit 12 makes the whole 16-bit word odd parity.
// - Filtered and crossing angle bit 12 gives odd parity over flags and angle.
// - Rotation count bits 11:0 are signed steps from the power-up angle.
// - Turn step is selectable as 180 or 45 degrees.
// - Count spans 512 rotations: -512..+511 or -2048..+2047.
// - Angle word bit 14 is set when any unmasked error or warning is set.
// - Angle word bit 13 is the masked OR of both supply low flags.
// - Filtered angle bits 11:0 hold the hysteresis angle, bit 15 reads 0.
// - Fine angle bits 14:0 hold the compensated angle, bit 15 reads 0.
// - Crossing angle bits 11:0 hold the uncompensated low-power angle, bit 15 zero.
// - Rotation counter follows the crossing path angle, not the compensated one.
// - Key bits 15:8 take code bytes write-only; bits 7:1 read zero.
// - Unlock only after writes 0x00, 0x27, 0x81, 0x1F, 0x77 in succession.
// - Configuration writes and special commands act only while unlocked.
// - Key bit 0 reads 1 while unlocked, 0 while locked.
// - Count passing its range sets a latched overflow, cleared by count reset.
// - Configuration reads need no unlock.
`timescale 1ns/10ps
`default_nettype none

module angle_turns_readout_unlock
  import readout_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             write_ignored_o,
  // Sensor results, same clock
  input  wire logic [11:0] filtered_angle_value_i,
  input  wire logic [14:0] fine_angle_i,
  input  wire logic [11:0] crossing_path_angle_i,
  // Configuration and flags, same clock
  input  wire logic        turn_step_45_i,
  input  wire logic        turns_reset_cmd_i,
  input  wire logic [15:0] error_flags_i,
  input  wire logic [15:0] warning_flags_i,
  input  wire logic [15:0] error_mask_i,
  input  wire logic [15:0] warning_mask_i,
  input  wire logic        mask_analog_low_i,
  input  wire logic        mask_digital_low_i,
  // Supply monitors, asynchronous
  input  wire logic        analog_supply_low_i,
  input  wire logic        digital_supply_low_i,
  // Configuration access gating
  input  wire logic        config_write_req_i,
  input  wire logic        config_read_req_i,
  input  wire logic        special_cmd_req_i,
  output logic             config_write_grant_o,
  output logic             config_write_refused_o,
  output logic             config_read_grant_o,
  output logic             special_cmd_grant_o,
  // Status
  output logic             unlocked_status_o,
  output logic             count_overflow_flag_o,
  output logic             supply_low_flag_o,
  output logic             error_summary_flag_o
);

  // Supply monitor synchronisers: three stages, accept when last two agree
  logic [1:0] sync_1;
  logic [1:0] sync_2;
  logic [1:0] sync_3;
  logic [1:0] supply_low_level;

  wire logic [1:0] supply_low_raw = {analog_supply_low_i, digital_supply_low_i};

  // Both monitors share one process so every stage vector keeps a single driver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_1           <= 2'h0;
      sync_2           <= 2'h0;
      sync_3           <= 2'h0;
      supply_low_level <= 2'h0;
    end else if (ce_i) begin
      sync_1 <= supply_low_raw;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      for (int i = 0; i < 2; i++) begin
        if (sync_2[i] == sync_3[i]) begin
          supply_low_level[i] <= sync_3[i];
        end
      end
    end
  end

  wire logic analog_supply_low  = supply_low_level[1];
  wire logic digital_supply_low = supply_low_level[0];

  // Rotation counter
  turns_if tif ();

  assign tif.ce      = ce_i;
  assign tif.step_45 = turn_step_45_i;
  assign tif.clear   = turns_reset_cmd_i;
  assign tif.angle   = crossing_path_angle_i;

  turn_step_counter u_counter (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tc    (tif.counter)
  );

  // Flag summaries
  wire logic [15:0] warning_all = {warning_flags_i[15:1], tif.overflow};
  wire logic        error_summary_flag =
    |(error_flags_i & ~error_mask_i) | |(warning_all & ~warning_mask_i);
  wire logic        supply_low_flag =
    (analog_supply_low && !mask_analog_low_i) || (digital_supply_low && !mask_digital_low_i);

  // Register address decode on the 16-bit word
  wire logic [6:0] word_addr     = reg_addr_i[7:1];
  wire logic       sel_count     = (word_addr == ROTATION_COUNT_OFS[7:1]);
  wire logic       sel_hyst      = (word_addr == HYSTERESIS_ANGLE_OFS[7:1]);
  wire logic       sel_fine      = (word_addr == FINE_ANGLE_OFS[7:1]);
  wire logic       sel_zero      = (word_addr == ZERO_CROSS_ANGLE_OFS[7:1]);
  wire logic       sel_key       = (word_addr == UNLOCK_KEY_OFS[7:1]);
  wire logic       sel_result    = sel_count || sel_hyst || sel_fine || sel_zero;

  // Result words
  wire logic [14:0] count_body = {ROTATION_COUNT_TAG, 12'(tif.count)};
  wire logic [15:0] count_word = {count_body[14:12], ~^count_body, count_body[11:0]};

  wire logic [14:0] hyst_body  = {1'b0, error_summary_flag, supply_low_flag, filtered_angle_value_i};
  wire logic [15:0] hyst_word  = {hyst_body[14:12], ~^hyst_body, hyst_body[11:0]};

  wire logic [15:0] fine_word  = {1'b0, fine_angle_i};

  wire logic [14:0] zero_body  = {1'b0, error_summary_flag, supply_low_flag, crossing_path_angle_i};
  wire logic [15:0] zero_word  = {zero_body[14:12], ~^zero_body, zero_body[11:0]};

  // Unlock key tracking
  key_state_e key_state;
  key_state_e next_key_state;
  key_state_e key_succ;

  wire logic       unlocked      = (key_state == KEY_OPEN);
  wire logic [15:0] key_word     = {8'h00, 7'h00, unlocked};
  wire logic       key_write     = reg_wr_i && sel_key;
  wire logic [7:0] key_byte      = reg_wdata_i[15:CODE_FIELD_LSB];
  // Once open, a new key write is compared against the first code again
  wire logic [7:0] expected_code =
    (key_state == KEY_WAIT_2) ? UNLOCK_CODE_2 :
    (key_state == KEY_WAIT_3) ? UNLOCK_CODE_3 :
    (key_state == KEY_WAIT_4) ? UNLOCK_CODE_4 :
    (key_state == KEY_WAIT_5) ? UNLOCK_CODE_5 :
    UNLOCK_CODE_1;
  wire logic       code_match    = (key_byte == expected_code);

  always_comb begin
    case (key_state)
      KEY_WAIT_1: key_succ = KEY_WAIT_2;
      KEY_WAIT_2: key_succ = KEY_WAIT_3;
      KEY_WAIT_3: key_succ = KEY_WAIT_4;
      KEY_WAIT_4: key_succ = KEY_WAIT_5;
      KEY_WAIT_5: key_succ = KEY_OPEN;
      KEY_OPEN:   key_succ = KEY_WAIT_2;
      default:    key_succ = KEY_WAIT_1;
    endcase
  end

  always_comb begin
    next_key_state = key_state;
    if (key_write) begin
      next_key_state = code_match ? key_succ : KEY_WAIT_1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_state <= KEY_WAIT_1;
    end else if (ce_i) begin
      key_state <= next_key_state;
    end
  end

  // Read data mux, unmapped words read as zero
  wire logic [15:0] read_word =
    sel_count ? count_word :
    sel_hyst  ? hyst_word  :
    sel_fine  ? fine_word  :
    sel_zero  ? zero_word  :
    sel_key   ? key_word   :
    WORD_RESET;

  // Register port answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o     <= WORD_RESET;
      reg_rvalid_o    <= 1'b0;
      write_ignored_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o    <= reg_rd_i;
      // Result registers have no write path at all
      write_ignored_o <= reg_wr_i && !sel_key;
      if (reg_rd_i) begin
        reg_rdata_o <= read_word;
      end
    end
  end

  // Configuration gating; a request on the locking write's cycle uses the old state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_write_grant_o   <= 1'b0;
      config_write_refused_o <= 1'b0;
      config_read_grant_o    <= 1'b0;
      special_cmd_grant_o    <= 1'b0;
    end else if (ce_i) begin
      config_write_grant_o   <= config_write_req_i && unlocked;
      config_write_refused_o <= config_write_req_i && !unlocked;
      config_read_grant_o    <= config_read_req_i;
      special_cmd_grant_o    <= special_cmd_req_i && unlocked;
    end
  end

  // Status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlocked_status_o     <= 1'b0;
      count_overflow_flag_o <= 1'b0;
      supply_low_flag_o     <= 1'b0;
      error_summary_flag_o  <= 1'b0;
    end else if (ce_i) begin
      unlocked_status_o     <= unlocked;
      count_overflow_flag_o <= tif.overflow;
      supply_low_flag_o     <= supply_low_flag;
      error_summary_flag_o  <= error_summary_flag;
    end
  end

endmodule

`default_nettype wire

//--- angle_turns_readout_unlock_monitor.sv
// Checker for the register port, unlock key and access gating
`timescale 1ns/10ps
`default_nettype none
module angle_turns_readout_unlock_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Register port
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        write_ignored_o,
  // Gating and status
  input wire logic        config_write_req_i,
  input wire logic        config_read_req_i,
  input wire logic        config_write_grant_o,
  input wire logic        config_write_refused_o,
  input wire logic        config_read_grant_o,
  input wire logic        mask_analog_low_i,
  input wire logic        mask_digital_low_i,
  input wire logic        supply_low_flag_o,
  input wire logic        unlocked_status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic       rd_take = reg_rd_i & ce_i;
  wire logic [6:0] word    = reg_addr_i[7:1];
  property p_tag; rd_take && word == 7'h16 |=> reg_rdata_o[15:13] == 3'b110; endproperty
  a_tag: assert property (p_tag) else $error("count word tag wrong");
  property p_cpar; rd_take && word == 7'h16 |=> ^reg_rdata_o; endproperty
  a_cpar: assert property (p_cpar) else $error("count word parity even");
  property p_apar; rd_take && (word == 7'h18 || word == 7'h1A) |=> ^reg_rdata_o && !reg_rdata_o[15]; endproperty
  a_apar: assert property (p_apar) else $error("angle word parity or top bit wrong");
  property p_key; rd_take && word == 7'h1E |=> reg_rdata_o[15:1] == 15'h0000; endproperty
  a_key: assert property (p_key) else $error("key word upper bits set");
  property p_open; $rose(unlocked_status_o) |->
    $past(reg_wr_i, 2) && ($past(reg_wdata_i, 2) & 16'hFF00) == 16'h7700; endproperty
  a_open: assert property (p_open) else $error("unlock without final code");
  property p_gate; config_write_req_i && ce_i |=> config_write_grant_o != config_write_refused_o; endproperty
  a_gate: assert property (p_gate) else $error("write request not answered once");
  property p_cread; config_read_req_i && ce_i |=> config_read_grant_o; endproperty
  a_cread: assert property (p_cread) else $error("config read not granted");
  property p_ign; reg_wr_i && ce_i && word != 7'h1E |=> write_ignored_o; endproperty
  a_ign: assert property (p_ign) else $error("result write not flagged ignored");
  property p_sup; (ce_i && mask_analog_low_i && mask_digital_low_i) [*8] |-> !supply_low_flag_o; endproperty
  a_sup: assert property (p_sup) else $error("masked supply low shown");
endmodule
bind angle_turns_readout_unlock angle_turns_readout_unlock_monitor u_mon (.clk_i, .rst_i, .ce_i, .reg_rd_i,
  .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .write_ignored_o, .config_write_req_i, .config_read_req_i,
  .config_write_grant_o, .config_write_refused_o, .config_read_grant_o, .mask_analog_low_i, .mask_digital_low_i,
  .supply_low_flag_o, .unlocked_status_o);
`default_nettype wire

//--- host_link_model.sv
// Host side model driving the register port
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  // Clock and read answer
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [15:0] rdata_i,
  // Requests
  output logic             rd_o,
  output logic             wr_o,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // Released lines are inverted so no stale value looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = v;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~v;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    @(posedge clk_i);
    v = rvalid_i ? rdata_i : 16'hxxxx;
    #1;
  endtask
  task automatic unlock();
    logic [7:0] seq [5] = '{8'h00, 8'h27, 8'h81, 8'h1F, 8'h77};
    foreach (seq[i]) wr(8'h3C, {seq[i], 8'h00});
  endtask
endmodule
`default_nettype wire

//--- readout_pkg.sv
// Shared constants and types for the angle, turns and unlock register block
`default_nettype none

package readout_pkg;

  // Register word offsets on the serial register port
  localparam logic [7:0] ROTATION_COUNT_OFS   = 8'h2C;
  localparam logic [7:0] HYSTERESIS_ANGLE_OFS = 8'h30;
  localparam logic [7:0] FINE_ANGLE_OFS       = 8'h32;
  localparam logic [7:0] ZERO_CROSS_ANGLE_OFS = 8'h34;
  localparam logic [7:0] UNLOCK_KEY_OFS       = 8'h3C;

  // Field positions
  localparam int PARITY_BIT       = 12;
  localparam int SUPPLY_LOW_BIT   = 13;
  localparam int ERROR_BIT        = 14;
  localparam int CODE_FIELD_LSB   = 8;
  localparam int OVERFLOW_WARN_BIT = 0;

  // Fixed tag in bits 15:13 of the rotation count word
  localparam logic [2:0] ROTATION_COUNT_TAG = 3'h6;

  // Unlock code bytes, in the order they must be written
  localparam logic [7:0] UNLOCK_CODE_1 = 8'h00;
  localparam logic [7:0] UNLOCK_CODE_2 = 8'h27;
  localparam logic [7:0] UNLOCK_CODE_3 = 8'h81;
  localparam logic [7:0] UNLOCK_CODE_4 = 8'h1F;
  localparam logic [7:0] UNLOCK_CODE_5 = 8'h77;

  // Signed count limits for the two step sizes
  localparam logic signed [11:0] COUNT_MAX_180 = 12'sh01FF;
  localparam logic signed [11:0] COUNT_MIN_180 = 12'sh0E00;
  localparam logic signed [11:0] COUNT_MAX_45  = 12'sh07FF;
  localparam logic signed [11:0] COUNT_MIN_45  = 12'sh0800;
  localparam logic signed [11:0] COUNT_ONE     = 12'sh0001;
  localparam logic signed [11:0] COUNT_RESET   = 12'sh0000;

  // Octant steps seen on the crossing path angle
  localparam logic [2:0] OCTANT_UP   = 3'h1;
  localparam logic [2:0] OCTANT_DOWN = 3'h7;

  // Reset values
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [2:0]  OCTANT_RESET = 3'h0;

  // Unlock sequence tracking
  typedef enum logic [2:0] {
    KEY_WAIT_1 = 3'b000,
    KEY_WAIT_2 = 3'b001,
    KEY_WAIT_3 = 3'b010,
    KEY_WAIT_4 = 3'b011,
    KEY_WAIT_5 = 3'b100,
    KEY_OPEN   = 3'b101
  } key_state_e;

endpackage

`default_nettype wire

//--- tb_angle_turns_readout_unlock.sv
// Self-checking bench for the angle, turns and unlock register block
`timescale 1ns/10ps
`default_nettype none
module tb_angle_turns_readout_unlock;
  import readout_pkg::*;
  typedef struct packed {logic [7:0] a; logic [11:0] ang; logic [14:0] fine;
                         logic [15:0] err, msk; logic low, mlow;} row_s;
  logic        clk_i, rst_i, ce_i, reg_rd_i, reg_wr_i, reg_rvalid_o, write_ignored_o, turn_step_45_i;
  logic        turns_reset_cmd_i, mask_analog_low_i, mask_digital_low_i, analog_supply_low_i, digital_supply_low_i;
  logic        config_write_req_i, config_read_req_i, special_cmd_req_i, config_write_grant_o, config_write_refused_o;
  logic        config_read_grant_o, special_cmd_grant_o, unlocked_status_o, count_overflow_flag_o;
  logic        supply_low_flag_o, error_summary_flag_o, ef, uv;
  logic [2:0]  oct;
  logic [7:0]  reg_addr_i;
  logic [11:0] filtered_angle_value_i, crossing_path_angle_i;
  logic [14:0] fine_angle_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, error_flags_i, warning_flags_i, error_mask_i, warning_mask_i, d, e;
  int          miscompares, n_tests;
  logic [7:0]  bad [7] = '{8'h00, 8'h27, 8'h99, 8'h27, 8'h81, 8'h1F, 8'h77};
  row_s rows [7] = '{'{8'h30, 12'hABC, 15'h0000, 16'h0001, 16'h0000, 1'b0, 1'b0},
                     '{8'h34, 12'h1F5, 15'h0000, 16'h0001, 16'h0001, 1'b1, 1'b0},
                     '{8'h31, 12'h000, 15'h0000, 16'h8000, 16'h0000, 1'b1, 1'b1},
                     '{8'h32, 12'h000, 15'h7FFF, 16'h0000, 16'h0000, 1'b0, 1'b0},
                     '{8'h2C, 12'h000, 15'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0},
                     '{8'h3C, 12'h000, 15'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0},
                     '{8'h40, 12'h000, 15'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0}};
  angle_turns_readout_unlock u_dut (.clk_i, .rst_i, .ce_i, .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .write_ignored_o, .filtered_angle_value_i, .fine_angle_i, .crossing_path_angle_i,
    .turn_step_45_i, .turns_reset_cmd_i, .error_flags_i, .warning_flags_i, .error_mask_i, .warning_mask_i,
    .mask_analog_low_i, .mask_digital_low_i, .analog_supply_low_i, .digital_supply_low_i, .config_write_req_i,
    .config_read_req_i, .special_cmd_req_i, .config_write_grant_o, .config_write_refused_o, .config_read_grant_o,
    .special_cmd_grant_o, .unlocked_status_o, .count_overflow_flag_o, .supply_low_flag_o, .error_summary_flag_o);
  host_link_model u_host (.clk_i, .rvalid_i(reg_rvalid_o), .rdata_i(reg_rdata_o), .rd_o(reg_rd_i), .wr_o(reg_wr_i),
                          .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rdc(input logic [11:0] v);
    tick(3);
    u_host.rd(8'h2C, d);
    chk(d, {3'b110, ~^v, v});
  endtask
  task automatic step(input int n, input logic up);
    repeat (n) begin
      oct = up ? oct + 3'h1 : oct - 3'h1;
      crossing_path_angle_i = {oct, 9'h000};
      tick(2);
    end
  endtask
  task automatic cfg(input int k, input logic [3:0] x);
    {config_write_req_i, config_read_req_i, special_cmd_req_i} = 3'b100 >> k;
    tick(1);
    {config_write_req_i, config_read_req_i, special_cmd_req_i} = 3'h0;
    chk({config_write_grant_o, config_write_refused_o, config_read_grant_o, special_cmd_grant_o}, {12'h000, x});
    tick(1);
  endtask
  task automatic tcmd();
    turns_reset_cmd_i = 1'b1;
    tick(1);
    turns_reset_cmd_i = 1'b0;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Longest stretch is the 2048 step overflow walk, about 4100 cycles
  initial begin
    #240000;
    miscompares++;
    close_out();
  end
  initial begin
    {rst_i, ce_i, turn_step_45_i} = 3'b111;
    {turns_reset_cmd_i, config_write_req_i, config_read_req_i, special_cmd_req_i} = 4'h0;
    {analog_supply_low_i, digital_supply_low_i, mask_analog_low_i, mask_digital_low_i} = 4'h0;
    {error_flags_i, warning_flags_i, error_mask_i, warning_mask_i} = {48'h0, 16'hFFFF};
    {filtered_angle_value_i, crossing_path_angle_i, fine_angle_i, oct} = '0;
    tick(12);
    rst_i = 1'b0;
    tick(2);
    chk({unlocked_status_o, count_overflow_flag_o, supply_low_flag_o}, 16'h0000);
    foreach (rows[i]) begin
      {filtered_angle_value_i, fine_angle_i} = {rows[i].ang, rows[i].fine};
      {error_flags_i, error_mask_i} = {rows[i].err, rows[i].msk};
      crossing_path_angle_i = rows[i].ang & 12'h1FF;
      {analog_supply_low_i, digital_supply_low_i} = {2{rows[i].low}};
      {mask_analog_low_i, mask_digital_low_i} = {2{rows[i].mlow}};
      ef = |(rows[i].err & ~rows[i].msk);
      uv = rows[i].low & ~rows[i].mlow;
      case (rows[i].a[7:1])
        7'h18: e = {1'b0, ef, uv, ~(ef ^ uv ^ (^rows[i].ang)), rows[i].ang};
        7'h1A: e = {1'b0, ef, uv, ~(ef ^ uv ^ (^crossing_path_angle_i)), crossing_path_angle_i};
        7'h19: e = {1'b0, rows[i].fine};
        7'h16: e = 16'hD000;
        default: e = 16'h0000;
      endcase
      tick(8);
      u_host.rd(rows[i].a, d);
      chk(d, e);
      chk({supply_low_flag_o, error_summary_flag_o}, {uv, ef});
    end
    {error_flags_i, analog_supply_low_i, digital_supply_low_i} = '0;
    $display("Test result words done");
    step(3, 1'b1);
    rdc(12'h003);
    step(4, 1'b0);
    rdc(12'hFFF);
    turn_step_45_i = 1'b0;
    step(5, 1'b1);
    rdc(12'h001);
    tcmd();
    turn_step_45_i = 1'b1;
    step(2047, 1'b1);
    rdc(12'h7FF);
    chk(count_overflow_flag_o, 16'h0000);
    step(1, 1'b1);
    rdc(12'h800);
    chk(count_overflow_flag_o, 16'h0001);
    warning_mask_i = 16'hFFFE;
    tick(2);
    chk(error_summary_flag_o, 16'h0001);
    warning_mask_i = 16'hFFFF;
    tcmd();
    rdc(12'h000);
    chk(count_overflow_flag_o, 16'h0000);
    $display("Test turns counter done");
    cfg(0, 4'b0100);
    cfg(1, 4'b0010);
    cfg(2, 4'b0000);
    u_host.unlock();
    tick(2);
    u_host.rd(8'h3C, d);
    chk(d, 16'h0001);
    cfg(0, 4'b1000);
    cfg(2, 4'b0001);
    fork
      u_host.wr(8'h30, 16'hFFFF);
      begin
        tick(1);
        chk(write_ignored_o, 16'h0001);
      end
    join
    tick(2);
    chk(unlocked_status_o, 16'h0001);
    u_host.wr(8'h3C, 16'h1200);
    tick(2);
    chk(unlocked_status_o, 16'h0000);
    foreach (bad[i]) u_host.wr(8'h3C, {bad[i], 8'h00});
    tick(2);
    chk(unlocked_status_o, 16'h0000);
    u_host.unlock();
    tick(2);
    chk(unlocked_status_o, 16'h0001);
    ce_i = 1'b0;
    u_host.wr(8'h3C, 16'h1200);
    tick(2);
    chk(unlocked_status_o, 16'h0001);
    ce_i = 1'b1;
    tick(2);
    chk(unlocked_status_o, 16'h0001);
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(2);
    chk(unlocked_status_o, 16'h0000);
    $display("Test unlock and gating done");
    close_out();
  end
endmodule
`default_nettype wire

//--- turn_step_counter.sv
// Signed turn step counter fed by the crossing path angle
`timescale 1ns/10ps
`default_nettype none

module turn_step_counter
  import readout_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Counter link
  turns_if.counter    tc
);

  logic [2:0]         prev_octant;
  logic               primed;
  logic signed [11:0] count;
  logic               overflow;

  wire logic [2:0]         octant     = tc.angle[11:9];
  wire logic [2:0]         step       = 3'(octant - prev_octant);
  // 180 degree steps count only on the 0 and 180 degree boundaries
  wire logic               step_up    = primed && (step == OCTANT_UP) &&
                                        (tc.step_45 || octant[1:0] == 2'b00);
  wire logic               step_down  = primed && (step == OCTANT_DOWN) &&
                                        (tc.step_45 || prev_octant[1:0] == 2'b00);
  wire logic signed [11:0] count_max  = tc.step_45 ? COUNT_MAX_45 : COUNT_MAX_180;
  wire logic signed [11:0] count_min  = tc.step_45 ? COUNT_MIN_45 : COUNT_MIN_180;
  wire logic               at_max     = (count == count_max);
  wire logic               at_min     = (count == count_min);
  wire logic               wrap_event = (step_up && at_max) || (step_down && at_min);
  // A jump of more than one octant between samples is not counted
  wire logic signed [11:0] next_count = tc.clear  ? COUNT_RESET :
                                        step_up   ? (at_max ? count_min : 12'(count + COUNT_ONE)) :
                                        step_down ? (at_min ? count_max : 12'(count - COUNT_ONE)) :
                                        count;
  // Overflow set wins over a same-cycle clear command
  wire logic               next_overflow = wrap_event || (overflow && !tc.clear);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_octant <= OCTANT_RESET;
      primed      <= 1'b0;
      count       <= COUNT_RESET;
      overflow    <= 1'b0;
    end else if (tc.ce) begin
      prev_octant <= octant;   // First sample after reset is the zero reference
      primed      <= 1'b1;
      count       <= next_count;
      overflow    <= next_overflow;
    end
  end

  assign tc.count    = count;
  assign tc.overflow = overflow;

endmodule

`default_nettype wire

//--- turns_if.sv
// Carrier between the register block and the rotation counter
`timescale 1ns/10ps
`default_nettype none

interface turns_if;
  logic               ce;
  logic               step_45;
  logic               clear;
  logic [11:0]        angle;
  logic signed [11:0] count;
  logic               overflow;

  modport counter (input ce, input step_45, input clear, input angle, output count, output overflow);
  modport user    (output ce, output step_45, output clear, output angle, input count, input overflow);
endinterface

`default_nettype wire
